// File: src/apf_formatter.sv
// Axis payload formatter: builds 12-byte packets on trigger events
//
// Contract
// - Trigger emits one packet per enabled type
// - Several types per axis share payload
// - Status bit 4 shows limit input
// - Status bit 5 shows homing input
// - Status bit 6 means reference valid
// - Status bit 14 means events queued
// - Status bit 15 flags position invalid
// - Invalid flag cleared only by command
// - Position type: 48-bit position bytes 4-9
// - Upper four bytes: period counter
// - Lower two bytes: 16-bit phase
// - Speed type: signed 48-bit speed
// - Reference type: zero phase, reference position
// - All types carry same status word
// - Payload in bytes 2-9, LSB first
// - Byte 1 frame counter, +1 per trigger
// - Byte 10 fixed filler
// - Byte 11 CRC-8 over bytes 0-9
//
// The address map and the APB slave port were left to the implementer.
module apf_formatter
    import apf_pkg::*;
(
    input wire logic mclk_in, // 10 MHz clock
    input wire logic rst_in, // Sync reset, high
    input wire logic ce_in, // Clock enable
    // APB slave
    input wire logic psel_in, // Select
    input wire logic penable_in, // Access phase
    input wire logic pwrite_in, // Write
    input wire logic [7:0] paddr_in, // Byte address
    input wire logic [31:0] pwdata_in, // Write data
    output logic pready_out, // Ready
    output logic pslverr_out, // Unmapped address
    output logic [31:0] prdata_out, // Read data
    output logic irq_out, // Level interrupt
    // Axis side
    input wire logic trig_in, // Trigger pulse
    input wire logic [31:0] period_in, // Period counter
    input wire logic [15:0] phase_in, // Interpolated phase
    input wire logic [47:0] speed_in, // Signed speed
    input wire logic [31:0] ref_pos_in, // Reference position
    input wire logic ref_valid_in, // Reference valid
    input wire logic event_pend_in, // Event queue not empty
    input wire logic pos_fault_in, // Position fault pulse
    input wire logic limit_input_in, // Limit pin
    input wire logic homing_input_in, // Homing pin
    // Packet stream
    output logic pkt_valid_out, // Byte valid
    output apf_beat_s pkt_out, // Byte with framing
    input wire logic pkt_ready_in // Sink ready
);

    // CRC-8 step over one byte, MSB first
    // Used once per byte; the loop unrolls into a small XOR tree
    function automatic logic [7:0] crc8(input logic [7:0] c,
                                        input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    // Address decode shared by read and write paths
    // Unmapped offsets answer with an error and ignore writes
    function automatic logic mapped(input logic [7:0] a);
        return a == REG_CTRL || a == REG_PKTNUM || a == REG_CMD ||
               a == REG_STATE || a == REG_IRQ_STS || a == REG_IRQ_MSK;
    endfunction

    logic [31:0] ctrl_q;
    logic [23:0] pktnum_q;
    logic [IRQ_W-1:0] irq_sts_q;
    logic [IRQ_W-1:0] irq_msk_q;
    logic pos_err_q;
    logic [2:0] lim_sync_q;
    logic [2:0] hom_sync_q;
    logic lim_q;
    logic hom_q;
    logic [7:0] fcnt_q;
    logic [7:0] fsnap_q;
    apf_snap_s snap_q;
    apf_state_e state_q;
    logic [NUM_TYPES-1:0] todo_q;
    logic [79:0] frame_q;
    logic [3:0] idx_q;
    logic [7:0] crc_q;
    logic [7:0] crc_d;
    logic [3:0] idx_d;
    logic [15:0] status_w;
    logic [63:0] payload_w;
    logic [NUM_TYPES-1:0] pick_w;
    logic [7:0] num_w;
    logic [7:0] next_byte_w;
    logic apb_acc;
    logic apb_wr;
    logic apb_rd;
    logic accept;
    logic trig_take;
    logic done_ev;

    assign apb_acc = ce_in && psel_in && penable_in && pready_out;
    assign apb_wr = apb_acc && pwrite_in && mapped(paddr_in);
    assign apb_rd = apb_acc && !pwrite_in;
    assign accept = pkt_valid_out && pkt_ready_in;
    assign trig_take = trig_in && state_q == ST_IDLE &&
                       ctrl_q[CTRL_EN_BIT] &&
                       ctrl_q[CTRL_TYPE_LSB +: NUM_TYPES] != '0;
    assign done_ev = state_q == ST_SEND && accept && idx_q == IDX_CRC;

    // Pin synchronisers; a change counts once stages 2 and 3 agree
    // Three stages trade four cycles of latency for immunity to
    // metastability and to single-cycle glitches on the pins
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            lim_sync_q <= 3'h0;
            hom_sync_q <= 3'h0;
            lim_q <= 1'b0;
            hom_q <= 1'b0;
        end else if (ce_in) begin
            lim_sync_q <= {lim_sync_q[1:0], limit_input_in};
            hom_sync_q <= {hom_sync_q[1:0], homing_input_in};
            if (lim_sync_q[1] == lim_sync_q[2]) begin
                lim_q <= lim_sync_q[2];
            end
            if (hom_sync_q[1] == hom_sync_q[2]) begin
                hom_q <= hom_sync_q[2];
            end
        end
    end

    // Status word, common to every packet type
    // Limit and homing come through the synchronisers, the other
    // bits come from logic on the same clock
    always_comb begin
        status_w = 16'h0000;
        status_w[STS_LIMIT] = lim_q;
        status_w[STS_HOMING] = hom_q;
        status_w[STS_REFVAL] = ref_valid_in;
        status_w[STS_EVENT] = event_pend_in;
        status_w[STS_POSERR] = pos_err_q;
    end

    // Sticky invalid flag; a fault in the clear cycle wins
    // Only the host command may clear it, so a brief fault is never lost
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pos_err_q <= 1'b0;
        end else if (ce_in) begin
            if (pos_fault_in) begin
                pos_err_q <= 1'b1;
            end else if (apb_wr && paddr_in == REG_CMD &&
                         pwdata_in[CMD_CLR_ERR_BIT]) begin
                pos_err_q <= 1'b0;
            end
        end
    end

    // Frame counter counts every trigger, even ones dropped as overrun
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            fcnt_q <= 8'h00;
        end else if (ce_in && trig_in) begin
            fcnt_q <= fcnt_q + 8'h01;
        end
    end

    // Frame count of the trigger being served; a dropped trigger still
    // moves the live counter, so all packets of one trigger keep this
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            fsnap_q <= 8'h00;
        end else if (ce_in && trig_take) begin
            fsnap_q <= fcnt_q + 8'h01;
        end
    end

    // Lowest pending type goes first
    // Types leave in a fixed order so the host can rely on it
    always_comb begin
        pick_w = todo_q & (~todo_q + 1'b1);
    end

    // Payload of the picked type, little-endian in the packet
    // Position is the default so that a stray pick stays harmless
    always_comb begin
        payload_w = {snap_q.period, snap_q.phase, snap_q.status};
        num_w = pktnum_q[8*TYPE_POS +: 8];
        if (pick_w[TYPE_SPEED]) begin
            payload_w = {snap_q.speed, snap_q.status};
            num_w = pktnum_q[8*TYPE_SPEED +: 8];
        end else if (pick_w[TYPE_REF]) begin
            payload_w = {snap_q.ref_pos, PHASE_ZERO, snap_q.status};
            num_w = pktnum_q[8*TYPE_REF +: 8];
        end
    end

    // Next byte and running CRC
    // The CRC covers bytes 0 to 9 only; the filler and the CRC byte
    // itself go out without touching the running value
    always_comb begin
        crc_d = crc_q;
        if (idx_q < IDX_FILL) begin
            crc_d = crc8(crc_q, pkt_out.data);
        end
        idx_d = idx_q + 4'h1;
        if (idx_d < IDX_FILL) begin
            next_byte_w = frame_q[8*idx_d +: 8];
        end else if (idx_d == IDX_FILL) begin
            next_byte_w = FILLER;
        end else begin
            next_byte_w = crc_d;
        end
    end

    // Packet sequencer; the sink may stall any byte
    // A trigger while busy is refused: the snapshot cannot hold two
    // triggers without a buffer
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            todo_q <= '0;
            snap_q <= '0;
            frame_q <= 80'h0;
            idx_q <= 4'h0;
            crc_q <= CRC_INIT;
            pkt_valid_out <= 1'b0;
            pkt_out <= '0;
        end else if (ce_in) begin
            case (state_q)
                ST_IDLE: begin
                    if (trig_take) begin
                        snap_q <= '{status_w, period_in, phase_in,
                                    speed_in, ref_pos_in};
                        todo_q <= ctrl_q[CTRL_TYPE_LSB +: NUM_TYPES];
                        state_q <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    // period above phase in the position word
                    frame_q <= {payload_w, fsnap_q, num_w};
                    todo_q <= todo_q & ~pick_w;
                    idx_q <= 4'h0;
                    crc_q <= CRC_INIT;
                    pkt_valid_out <= 1'b1;
                    pkt_out <= '{1'b1, 1'b0, num_w};
                    state_q <= ST_SEND;
                end
                ST_SEND: begin
                    if (accept) begin
                        crc_q <= crc_d;
                        idx_q <= idx_d;
                        if (idx_q == IDX_CRC) begin
                            pkt_valid_out <= 1'b0;
                            pkt_out <= '0;
                            state_q <= (todo_q != '0) ? ST_LOAD : ST_IDLE;
                        end else begin
                            pkt_out <= '{1'b0, idx_d == IDX_CRC,
                                         next_byte_w};
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Writable registers
    // Control keeps only the enable and type bits; the rest read zero
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ctrl_q <= 32'h0;
            pktnum_q <= PKTNUM_RST;
            irq_msk_q <= '0;
        end else if (apb_wr) begin
            if (paddr_in == REG_CTRL) begin
                ctrl_q <= 32'(pwdata_in[NUM_TYPES:0]);
            end
            if (paddr_in == REG_PKTNUM) begin
                pktnum_q <= pwdata_in[23:0];
            end
            if (paddr_in == REG_IRQ_MSK) begin
                irq_msk_q <= pwdata_in[IRQ_W-1:0];
            end
        end
    end

    // Sticky interrupt status; read clears, new events win
    // An event in the clearing read cycle is kept; one in the setup cycle,
    // after the read data is taken, is cleared without being read
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            irq_sts_q <= '0;
            irq_out <= 1'b0;
        end else if (ce_in) begin
            logic [IRQ_W-1:0] ev;
            logic [IRQ_W-1:0] nxt;
            ev = '0;
            ev[IRQ_DONE] = done_ev;
            ev[IRQ_OVERRUN] = trig_in && state_q != ST_IDLE;
            ev[IRQ_POSERR] = pos_fault_in && !pos_err_q;
            nxt = irq_sts_q;
            if (apb_rd && paddr_in == REG_IRQ_STS) begin
                nxt = '0;
            end
            nxt = nxt | ev;
            irq_sts_q <= nxt;
            irq_out <= |(nxt & irq_msk_q);
        end
    end

    // APB answer: one wait-free access cycle after setup
    // No back-pressure is needed because every register is a local
    // flip-flop
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
        end else if (ce_in) begin
            pready_out <= psel_in && !penable_in;
            pslverr_out <= psel_in && !penable_in && !mapped(paddr_in);
            if (psel_in && !penable_in) begin
                case (paddr_in)
                    REG_CTRL: prdata_out <= ctrl_q;
                    REG_PKTNUM: prdata_out <= 32'(pktnum_q);
                    REG_STATE: prdata_out <= 32'({todo_q, fcnt_q,
                                                  state_q != ST_IDLE,
                                                  pos_err_q});
                    REG_IRQ_STS: prdata_out <= 32'(irq_sts_q);
                    REG_IRQ_MSK: prdata_out <= 32'(irq_msk_q);
                    default: prdata_out <= 32'h0;
                endcase
            end
        end
    end

endmodule

// File: src/apf_pkg.sv
// Package: constants and types of the axis payload formatter
package apf_pkg;
    // APB register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PKTNUM = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;
    localparam logic [7:0] REG_STATE = 8'h0C;
    localparam logic [7:0] REG_IRQ_STS = 8'h10;
    localparam logic [7:0] REG_IRQ_MSK = 8'h14;
    // Control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_TYPE_LSB = 1;
    localparam int NUM_TYPES = 3;
    localparam int TYPE_POS = 0;
    localparam int TYPE_SPEED = 1;
    localparam int TYPE_REF = 2;
    localparam int CMD_CLR_ERR_BIT = 0;
    localparam logic [23:0] PKTNUM_RST = 24'h030201;
    // Interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OVERRUN = 1;
    localparam int IRQ_POSERR = 2;
    localparam int IRQ_W = 3;
    // Status word bit positions
    localparam int STS_LIMIT = 4;
    localparam int STS_HOMING = 5;
    localparam int STS_REFVAL = 6;
    localparam int STS_EVENT = 14;
    localparam int STS_POSERR = 15;
    // Packet layout
    localparam logic [3:0] IDX_FILL = 4'hA;
    localparam logic [3:0] IDX_CRC = 4'hB;
    localparam logic [7:0] FILLER = 8'hBC;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [15:0] PHASE_ZERO = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOAD = 3'b010,
        ST_SEND = 3'b100
    } apf_state_e;

    // Values frozen at the trigger
    typedef struct packed {
        logic [15:0] status;
        logic [31:0] period;
        logic [15:0] phase;
        logic [47:0] speed;
        logic [31:0] ref_pos;
    } apf_snap_s;

    // One beat of the outgoing byte stream
    typedef struct packed {
        logic sof;
        logic eof;
        logic [7:0] data;
    } apf_beat_s;
endpackage

// File: tb/apf_sva.sv
// Checker: bus and framing properties seen at the formatter ports
module apf_sva import apf_pkg::*; (
    input wire logic mclk_in, // Clock
    input wire logic rst_in, // Sync reset
    input wire logic psel_in, // Select
    input wire logic penable_in, // Access phase
    input wire logic pready_out, // Ready
    input wire logic pslverr_out, // Error
    input wire logic [31:0] prdata_out, // Read data
    input wire logic pkt_valid_out, // Byte valid
    input wire apf_beat_s pkt_out, // Byte with framing
    input wire logic pkt_ready_in // Sink ready
);
    logic [3:0] idx_q; // Byte position inside the current packet
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // Count accepted bytes so the sof, eof, filler and reserved-bit properties know which byte is on the wire
    always_ff @(posedge mclk_in) begin
        if (rst_in)
            idx_q <= 4'h0;
        else if (pkt_valid_out && pkt_ready_in)
            idx_q <= pkt_out.eof ? 4'h0 : idx_q + 4'h1;
    end
    property p_rdy_setup; psel_in && !penable_in |=> pready_out; endproperty
    a_rdy_setup: assert property (p_rdy_setup) else $error("late ready");
    property p_rdy_one; pready_out |=> !pready_out; endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
    property p_err; pslverr_out |-> pready_out && prdata_out == 0; endproperty
    a_err: assert property (p_err) else $error("bad error reply");
    property p_hold;
        pkt_valid_out && !pkt_ready_in |=> pkt_valid_out && $stable(pkt_out);
    endproperty
    a_hold: assert property (p_hold) else $error("byte dropped");
    property p_sof;
        pkt_valid_out |-> pkt_out.sof == (idx_q == 4'h0);
    endproperty
    a_sof: assert property (p_sof) else $error("sof misplaced");
    property p_eof;
        pkt_valid_out |-> pkt_out.eof == (idx_q == IDX_CRC);
    endproperty
    a_eof: assert property (p_eof) else $error("eof misplaced");
    property p_fill;
        pkt_valid_out && idx_q == IDX_FILL |-> pkt_out.data == FILLER;
    endproperty
    a_fill: assert property (p_fill) else $error("bad filler");
    property p_rsv;
        pkt_valid_out && idx_q == 4'h2 |-> pkt_out.data[3:0] == 4'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved low set");
    property p_rsv_hi;
        pkt_valid_out && idx_q == 4'h3 |-> pkt_out.data[5:0] == 6'h00;
    endproperty
    a_rsv_hi: assert property (p_rsv_hi) else $error("reserved high set");
    property p_gap;
        pkt_valid_out && pkt_ready_in && pkt_out.eof |=> !pkt_valid_out;
    endproperty
    a_gap: assert property (p_gap) else $error("no gap");
endmodule

// File: tb/apf_sink.sv
// Packet sink: collects framed bytes into whole packets
module apf_sink import apf_pkg::*; (
    input wire logic clk_in, // Clock
    input wire logic rst_in, // Sync reset
    input wire logic valid_in, // Byte valid
    input wire logic slow_in, // Stall every other cycle
    input wire apf_beat_s beat_in, // Byte with framing
    output logic ready_out // Ready to take a byte
);
    logic [95:0] acc;
    logic [95:0] pkts[$];
    int n = 0;
    // Slow mode stalls half the cycles to exercise byte holding
    always_ff @(posedge clk_in) begin
        if (rst_in)
            ready_out <= 1'b0;
        else
            ready_out <= slow_in ? ~ready_out : 1'b1;
    end
    // First byte lands lowest, so payload reads back little-endian
    always @(posedge clk_in) begin
        if (!rst_in && valid_in && ready_out) begin
            acc[8*n+:8] = beat_in.data;
            n = beat_in.eof ? 0 : n + 1;
            if (beat_in.eof)
                pkts.push_back(acc);
        end
    end
endmodule

// File: tb/tb.sv
// Testbench: packet types, status bits and register access
module tb import apf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in = 0, rst_in = 1, ce_in = 1, slow = 0;
    logic psel_in = 0, penable_in = 0, pwrite_in = 0, trig_in = 0;
    logic [7:0] paddr_in = 0;
    logic [31:0] pwdata_in = 0, period_in = 32'h89ABCDEF;
    logic [15:0] phase_in = 16'h1357;
    logic [47:0] speed_in = 48'hFEDCBA987654;
    logic [31:0] ref_pos_in = 32'h2468ACE0;
    logic ref_valid_in = 0, event_pend_in = 0, pos_fault_in = 0;
    logic limit_input_in = 0, homing_input_in = 0;
    logic pready_out, pslverr_out, irq_out, pkt_valid_out, pkt_ready_in;
    logic [31:0] prdata_out, r;
    apf_beat_s pkt_out;
    logic e;
    int n_mismatch = 0, num_checks = 0;
    apf_formatter u_dut(.mclk_in, .rst_in, .ce_in, .psel_in, .penable_in,
        .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .pslverr_out,
        .prdata_out, .irq_out, .trig_in, .period_in, .phase_in, .speed_in,
        .ref_pos_in, .ref_valid_in, .event_pend_in, .pos_fault_in,
        .limit_input_in, .homing_input_in, .pkt_valid_out, .pkt_out,
        .pkt_ready_in);
    apf_sink u_sink(.clk_in(mclk_in), .rst_in, .valid_in(pkt_valid_out),
        .slow_in(slow), .beat_in(pkt_out), .ready_out(pkt_ready_in));
    // Free running 10 MHz clock
    initial begin
        forever #50 mclk_in = ~mclk_in;
    end
    task summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [95:0] s, input logic [95:0] x);
        num_checks++;
        if (s !== x) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, x, s);
        end
    endtask
    // Request held until ready is sampled high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk_in);
        {psel_in, penable_in, pwrite_in} <= {2'b10, w};
        {paddr_in, pwdata_in} <= {a, d};
        @(posedge mclk_in);
        penable_in <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk_in);
            if (pready_out === 1'b1) break;
        end
        if (i == 20) begin
            n_mismatch++;
            summarize();
        end
        r = prdata_out;
        e = pslverr_out;
        {psel_in, penable_in} <= 2'b00;
    endtask
    task pulse(input int f);
        @(posedge mclk_in);
        if (f) pos_fault_in <= 1'b1; else trig_in <= 1'b1;
        @(posedge mclk_in);
        {pos_fault_in, trig_in} <= 2'b00;
    endtask
    // CRC-8 over bytes 0..9, byte 0 first, MSB first
    function logic [7:0] crc8(input logic [79:0] v);
        logic [7:0] c;
        logic fb;
        c = CRC_INIT;
        for (int b = 0; b < 10; b++)
            for (int k = 7; k >= 0; k--) begin
                fb = c[7] ^ v[8*b+k];
                c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
            end
        return c;
    endfunction
    // Pop the next packet and compare it whole against the layout
    task cmp(input int t, input logic [15:0] st, input logic [7:0] f);
        logic [63:0] p;
        logic [79:0] h;
        int i;
        for (i = 0; i < 400 && u_sink.pkts.size() == 0; i++)
            @(posedge mclk_in);
        if (i == 400) begin
            n_mismatch++;
            summarize();
        end
        p = t == TYPE_POS ? {period_in, phase_in, st} : t == TYPE_SPEED ?
            {speed_in, st} : {ref_pos_in, PHASE_ZERO, st};
        h = {p, f, PKTNUM_RST[8*t+:8]};
        chk("packet", u_sink.pkts.pop_front(), {crc8(h), FILLER, h});
    endtask
    task s_regs();
        apb(0, REG_PKTNUM, 0);
        chk("pktnum", r, {8'h00, PKTNUM_RST});
        apb(0, 8'h20, 0);
        chk("unmapped", {e, r}, {1'b1, 32'h0});
    endtask
    // All types on one trigger, a second trigger while busy is dropped
    task s_types();
        {limit_input_in, ref_valid_in, event_pend_in} <= 3'b111;
        apb(1, REG_CTRL, 32'h0000000F);
        pulse(0);
        repeat (4) @(posedge mclk_in);
        pulse(0);
        for (int t = 0; t < NUM_TYPES; t++)
            cmp(t, 16'h4050, 8'h01);
        repeat (40) @(posedge mclk_in);
        chk("extra", u_sink.pkts.size(), 0);
    endtask
    // Fault is sticky across triggers until the clear command
    task s_poserr();
        {limit_input_in, ref_valid_in, event_pend_in} <= 3'b000;
        homing_input_in <= 1'b1;
        slow <= 1'b1;
        apb(1, REG_IRQ_MSK, 32'h4);
        apb(1, REG_CTRL, 32'h3);
        pulse(1);
        repeat (5) @(posedge mclk_in);
        chk("irq", irq_out, 1);
        pulse(0);
        cmp(TYPE_POS, 16'h8020, 8'h03);
        pulse(0);
        cmp(TYPE_POS, 16'h8020, 8'h04);
        apb(0, REG_IRQ_STS, 0);
        chk("sts", r[IRQ_W-1:0], 3'b111);
        @(posedge mclk_in);
        chk("irq clr", irq_out, 0);
        apb(1, REG_CMD, 32'h1);
        pulse(0);
        cmp(TYPE_POS, 16'h0020, 8'h05);
    endtask
    initial begin
        repeat (10) @(posedge mclk_in);
        rst_in <= 1'b0;
        s_regs();
        s_types();
        s_poserr();
        summarize();
    end
endmodule
bind apf_formatter apf_sva u_sva(.mclk_in, .rst_in, .psel_in, .penable_in,
    .pready_out, .pslverr_out, .prdata_out, .pkt_valid_out, .pkt_out,
    .pkt_ready_in);
